//--- src/omc_pkg.sv
// Constants, types and register map shared by both ends of the mode link.
// Assumes a single 100 MHz core clock and an active-high async reset.
package omc_pkg;
   // ==========================================================
   // Device register map
   localparam logic [7:0] MODE_CONTROL_ADDR = 8'h01;
   localparam logic [7:0] MODE_STATUS_ADDR = 8'h1C;
   localparam int SOFT_RESET_BIT = 0;
   localparam int LOW_POWER_SELECT_BIT = 3;
   localparam int STANDBY_SELECT_BIT = 4;
   localparam int LS_ENABLE_BIT = 7;
   localparam int WDOG_ENABLE_BIT = 8;
   localparam logic [15:0] MODE_CONTROL_RESET = 16'h0001;
   localparam int STAT_ACTIVE = 0;
   localparam int STAT_LOW_POWER = 1;
   localparam int STAT_STANDBY = 2;
   localparam int STAT_INTERMITTENT = 3;
   localparam int STAT_SHUTDOWN = 4;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int STANDBY_EXIT_US = 3000;
   localparam int STANDBY_EXIT_CYC = STANDBY_EXIT_US * CLK_MHZ + 1;
   localparam int WDOG_SEC = 60;
   localparam longint WDOG_CYC = longint'(WDOG_SEC) * 1000000 * CLK_MHZ;
   localparam int LINK_DIV = 4;
   // ==========================================================
   // Controller APB registers
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_WDATA = 8'h04;
   localparam logic [7:0] APB_STATUS = 8'h08;
   localparam logic [7:0] APB_RDATA = 8'h0C;
   localparam logic [7:0] APB_PINS = 8'h10;
   // ==========================================================
   // Mode states
   typedef enum logic [2:0] {
      MS_SHUTDOWN = 3'b000,
      MS_ACTIVE = 3'b001,
      MS_LOW_POWER = 3'b010,
      MS_STANDBY = 3'b011
   } omc_mode_e;
endpackage : omc_pkg

//--- src/omc_link_if.sv
// Pin-level link between the mode device and its host controller.
// Assumes both ends clocked by the same core clock in the bench.
`timescale 1ns/1ps
interface omc_link_if;
   logic sclk;
   logic sdi;
   logic spiEnable;
   logic spiDataOut;
   logic spiDataOutEn;
   logic powerResetOutEn;
   logic wakeInput;
   logic shutdownControlIn;
   // Open-drain reset reads high unless pulled low
   wire powerResetLine = powerResetOutEn ? 1'b0 : 1'b1;
   modport device (input sclk, input sdi, input spiEnable,
      input wakeInput, input shutdownControlIn, output spiDataOut,
      output spiDataOutEn, output powerResetOutEn);
   modport host (output sclk, output sdi, output spiEnable,
      output wakeInput, output shutdownControlIn, input spiDataOut,
      input spiDataOutEn, input powerResetLine);
endinterface : omc_link_if

//--- src/omc_device.sv
// Operating-mode controller of the battery monitor with its serial port.
// Assumes link pins asynchronous to core_clk; frames of 24 bits:
// bit 23 write flag, 22:16 address, 15:0 data, msb first, mode 0.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module omc_device #(
   parameter longint WDOG_CYCLES = omc_pkg::WDOG_CYC,
   parameter int STBY_CYCLES = omc_pkg::STANDBY_EXIT_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Link
   omc_link_if.device link,
   // Supply sense and measurement permits
   input wire logic supplyPresent,
   output logic cellConvEnable,
   output logic hsCurrentEnable,
   output logic lsCurrentEnable,
   output logic protectEnable,
   output logic spiAvailable
);
   logic [1:0] sclkSync, sdiSync, senSync, wakeSync, shdnSync;
   logic sclkPrev_q;
   omc_pkg::omc_mode_e mode_q, mode_d;
   logic [15:0] modeControl_q;
   logic [23:0] shift_q;
   logic [4:0] bitCount_q;
   logic [15:0] readShift_q;
   logic frameDone, wrCtrl;
   logic [15:0] frameData;
   logic [1:0] supplySync;
   logic softResetFlag_q;
   logic [63:0] wdogCount_q;
   logic [31:0] senHigh_q;
   logic [4:0] statusBits;
   logic sclkRise, sclkFall, linkOn;

   // ==========================================================
   // Input synchronisers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclkSync <= 2'h0;
         sdiSync <= 2'h0;
         senSync <= 2'h0;
         wakeSync <= 2'h0;
         shdnSync <= 2'h3;
         supplySync <= 2'h0;
         sclkPrev_q <= 1'b0;
      end else begin
         sclkSync <= {sclkSync[0], link.sclk};
         sdiSync <= {sdiSync[0], link.sdi};
         senSync <= {senSync[0], link.spiEnable};
         wakeSync <= {wakeSync[0], link.wakeInput};
         shdnSync <= {shdnSync[0], link.shutdownControlIn};
         supplySync <= {supplySync[0], supplyPresent};
         sclkPrev_q <= sclkSync[1];
      end
   end
   assign sclkRise = sclkSync[1] & ~sclkPrev_q;
   assign sclkFall = ~sclkSync[1] & sclkPrev_q;
   // Serial port only alive in Active and Low Power
   assign linkOn = (mode_q == omc_pkg::MS_ACTIVE) ||
      (mode_q == omc_pkg::MS_LOW_POWER);
   assign frameDone = linkOn && senSync[1] && sclkRise &&
      (bitCount_q == 5'd23);
   assign wrCtrl = frameDone && shift_q[22] &&
      ({shift_q[21:15]} == omc_pkg::MODE_CONTROL_ADDR[6:0]);
   // Last data bit is still in the synchroniser at frame end
   assign frameData = {shift_q[14:0], sdiSync[1]};

   // ==========================================================
   // Frame shifter, samples on rising serial clock
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_q <= 24'h000000;
         bitCount_q <= 5'h00;
      end else if (!senSync[1] || !linkOn) begin
         bitCount_q <= 5'h00;
      end else if (sclkRise) begin
         shift_q <= {shift_q[22:0], sdiSync[1]};
         bitCount_q <= (bitCount_q == 5'd23) ? 5'h00 : bitCount_q + 5'd1;
      end
   end

   // ==========================================================
   // Read data, loaded after the address byte
   assign statusBits = {mode_q == omc_pkg::MS_SHUTDOWN, 1'b0,
      mode_q == omc_pkg::MS_STANDBY, mode_q == omc_pkg::MS_LOW_POWER,
      mode_q == omc_pkg::MS_ACTIVE};
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         readShift_q <= 16'h0000;
      end else if (sclkRise && bitCount_q == 5'd7) begin
         readShift_q <= ({shift_q[5:0], sdiSync[1]} ==
            omc_pkg::MODE_STATUS_ADDR[6:0]) ? {11'h000, statusBits} :
            ({shift_q[5:0], sdiSync[1]} == omc_pkg::MODE_CONTROL_ADDR[6:0]) ?
            modeControl_q : 16'h0000;
      end else if (sclkFall && bitCount_q > 5'd7) begin
         readShift_q <= {readShift_q[14:0], 1'b0};
      end
   end

   // ==========================================================
   // Mode control register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         modeControl_q <= omc_pkg::MODE_CONTROL_RESET;
      end else if (wrCtrl && !frameData[omc_pkg::SOFT_RESET_BIT]) begin
         modeControl_q <= omc_pkg::MODE_CONTROL_RESET;
      end else if (wrCtrl) begin
         modeControl_q <= frameData;
      end else if (mode_q != omc_pkg::MS_LOW_POWER &&
            mode_q != omc_pkg::MS_ACTIVE) begin
         // Selects clear while the mode is Standby or Shutdown
         modeControl_q[omc_pkg::STANDBY_SELECT_BIT] <= 1'b0;
         modeControl_q[omc_pkg::LOW_POWER_SELECT_BIT] <= 1'b0;
      end
   end

   // ==========================================================
   // Soft reset acknowledge on data out
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         softResetFlag_q <= 1'b0;
      end else if (wrCtrl && !frameData[omc_pkg::SOFT_RESET_BIT]) begin
         softResetFlag_q <= 1'b1;
      end else if ((senSync[1] && sclkRise) || !linkOn) begin
         // Flag stands until the next frame starts shifting
         softResetFlag_q <= 1'b0;
      end
   end
   assign link.spiDataOut = softResetFlag_q | readShift_q[15];
   assign link.spiDataOutEn = linkOn;

   // ==========================================================
   // Communication watchdog
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdogCount_q <= 64'h0;
      end else if (frameDone || mode_q == omc_pkg::MS_SHUTDOWN) begin
         wdogCount_q <= 64'h0;
      end else if (modeControl_q[omc_pkg::WDOG_ENABLE_BIT]) begin
         wdogCount_q <= wdogCount_q + 64'h1;
      end
   end

   // ==========================================================
   // Standby exit timer on enable held high
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         senHigh_q <= 32'h0;
      end else if (mode_q != omc_pkg::MS_STANDBY || !senSync[1]) begin
         senHigh_q <= 32'h0;
      end else if (senHigh_q < 32'(STBY_CYCLES)) begin
         senHigh_q <= senHigh_q + 32'h1;
      end
   end

   // ==========================================================
   // Mode state machine
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         omc_pkg::MS_SHUTDOWN: begin
            if (!shdnSync[1] && supplySync[1] && wakeSync[1])
               mode_d = omc_pkg::MS_ACTIVE;
         end
         omc_pkg::MS_ACTIVE: begin
            if (modeControl_q[omc_pkg::STANDBY_SELECT_BIT])
               mode_d = omc_pkg::MS_STANDBY;
            else if (modeControl_q[omc_pkg::LOW_POWER_SELECT_BIT])
               mode_d = omc_pkg::MS_LOW_POWER;
         end
         omc_pkg::MS_LOW_POWER: begin
            if (modeControl_q[omc_pkg::STANDBY_SELECT_BIT])
               mode_d = omc_pkg::MS_STANDBY;
            else if (!modeControl_q[omc_pkg::LOW_POWER_SELECT_BIT])
               mode_d = omc_pkg::MS_ACTIVE;
         end
         omc_pkg::MS_STANDBY: begin
            if (senHigh_q >= 32'(STBY_CYCLES))
               mode_d = omc_pkg::MS_ACTIVE;
         end
         default: mode_d = omc_pkg::MS_SHUTDOWN;
      endcase
      if (shdnSync[1])
         mode_d = omc_pkg::MS_SHUTDOWN;
      else if (mode_q != omc_pkg::MS_SHUTDOWN && !wakeSync[1] &&
            modeControl_q[omc_pkg::WDOG_ENABLE_BIT] &&
            wdogCount_q >= 64'(WDOG_CYCLES))
         mode_d = omc_pkg::MS_SHUTDOWN;
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) mode_q <= omc_pkg::MS_SHUTDOWN;
      else mode_q <= mode_d;
   end

   // ==========================================================
   // Power reset output and measurement permits
   assign link.powerResetOutEn = (mode_q == omc_pkg::MS_SHUTDOWN);
   assign cellConvEnable = (mode_q == omc_pkg::MS_ACTIVE);
   assign hsCurrentEnable = (mode_q == omc_pkg::MS_ACTIVE);
   assign protectEnable = (mode_q != omc_pkg::MS_SHUTDOWN);
   assign lsCurrentEnable = (mode_q != omc_pkg::MS_SHUTDOWN) &&
      modeControl_q[omc_pkg::LS_ENABLE_BIT];
   assign spiAvailable = linkOn;
endmodule : omc_device

//--- src/omc_host.sv
// Host controller: APB slave that drives the link pins to the device.
// Assumes APB on core_clk; device answers sampled through synchronisers.
`timescale 1ns/1ps
module omc_host (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link
   omc_link_if.host link
);
   logic [23:0] frame_q;
   logic [4:0] bitCount_q;
   logic [1:0] divCount_q;
   logic busy_q, sclk_q, sen_q, wake_q, shutdown_control_in_q, senHold_q;
   logic [15:0] rdata_q;
   logic [1:0] sdoSync, rstSync;
   logic apbWr, divTick;

   assign apbWr = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign divTick = (divCount_q == 2'(omc_pkg::LINK_DIV - 1));

   // ==========================================================
   // Synchronise device outputs
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdoSync <= 2'h0;
         rstSync <= 2'h0;
      end else begin
         sdoSync <= {sdoSync[0], link.spiDataOut};
         rstSync <= {rstSync[0], link.powerResetLine};
      end
   end

   // ==========================================================
   // Pin control register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wake_q <= 1'b0;
         shutdown_control_in_q <= 1'b0;
         senHold_q <= 1'b0;
      end else if (apbWr && paddr == omc_pkg::APB_PINS) begin
         wake_q <= pwdata[0];
         shutdown_control_in_q <= pwdata[1];
         senHold_q <= pwdata[2];
      end
   end

   // ==========================================================
   // Frame engine, mode 0, one bit per two divider ticks
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_q <= 24'h000000;
         bitCount_q <= 5'h00;
         divCount_q <= 2'h0;
         busy_q <= 1'b0;
         sclk_q <= 1'b0;
         sen_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else if (!busy_q) begin
         divCount_q <= 2'h0;
         if (apbWr && paddr == omc_pkg::APB_CMD) begin
            frame_q <= {pwdata[16], pwdata[14:8], rdata_q[15:0]};
            busy_q <= 1'b1;
            sen_q <= 1'b1;
            bitCount_q <= 5'h00;
         end else if (apbWr && paddr == omc_pkg::APB_WDATA) begin
            rdata_q <= pwdata[15:0]; // Staged write data
         end
      end else begin
         divCount_q <= divCount_q + 2'h1;
         if (divTick) begin
            if (!sclk_q) begin
               sclk_q <= 1'b1;
               rdata_q <= {rdata_q[14:0], sdoSync[1]};
            end else begin
               sclk_q <= 1'b0;
               frame_q <= {frame_q[22:0], 1'b0};
               bitCount_q <= bitCount_q + 5'd1;
               if (bitCount_q == 5'd23) begin
                  busy_q <= 1'b0;
                  sen_q <= 1'b0;
               end
            end
         end
      end
   end

   // ==========================================================
   // Pin drive and APB read mux
   assign link.sclk = sclk_q;
   assign link.sdi = frame_q[23];
   assign link.spiEnable = sen_q | senHold_q;
   assign link.wakeInput = wake_q;
   assign link.shutdownControlIn = shutdown_control_in_q;
   always_comb begin
      case (paddr)
         omc_pkg::APB_STATUS: prdata = {29'h0, sdoSync[1], rstSync[1],
            busy_q};
         omc_pkg::APB_RDATA: prdata = {16'h0000, rdata_q};
         omc_pkg::APB_PINS: prdata = {29'h0, senHold_q, shutdown_control_in_q, wake_q};
         default: prdata = 32'h00000000;
      endcase
   end
endmodule : omc_host

//--- bench/omc_link_properties.sv
// Concurrent checks on the mode link pins and the device permits.
// Assumes one core clock domain and an active-high async reset.
`timescale 1ns/1ps
module omc_link_properties #(
   parameter int STBY_CYCLES = 50
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Link pins
   input wire logic spiEnable,
   input wire logic spiDataOutEn,
   input wire logic powerResetOutEn,
   input wire logic wakeInput,
   input wire logic shutdownControlIn,
   // Device supply sense and permits
   input wire logic supplyPresent,
   input wire logic cellConvEnable,
   input wire logic hsCurrentEnable,
   input wire logic lsCurrentEnable,
   input wire logic protectEnable,
   input wire logic spiAvailable
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Helpers
   logic [15:0] holdCnt_q;
   // Cycles of enable held high, saturating
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) holdCnt_q <= 16'h0000;
      else if (!spiEnable) holdCnt_q <= 16'h0000;
      else if (holdCnt_q != 16'hFFFF) holdCnt_q <= holdCnt_q + 16'h0001;
   end
   // Mode steps
   sequence inStandby;
      protectEnable && !spiAvailable;
   endsequence
   sequence wakeGranted;
      $fell(powerResetOutEn);
   endsequence
   sequence longHold;
      (holdCnt_q == 16'(STBY_CYCLES + 8)) && !powerResetOutEn;
   endsequence
   // ==========================================================
   // Assertions
   chk_shutdown_control_in_forces_off:
      assert property (shutdownControlIn |-> ##[0:6] powerResetOutEn)
      else $error("shutdown input did not force shutdown");
   chk_shutdown_control_in_no_permit:
      assert property (powerResetOutEn |-> !protectEnable && !cellConvEnable
         && !lsCurrentEnable && !spiAvailable)
      else $error("permit given in shutdown");
   chk_wake_cause:
      assert property (wakeGranted |-> $past(wakeInput) && $past(supplyPresent)
         && !shutdownControlIn)
      else $error("wake without its conditions");
   chk_wake_active:
      assert property (wakeGranted |-> ##[0:2] cellConvEnable && spiAvailable)
      else $error("first wake did not enter active");
   chk_conv_active:
      assert property (cellConvEnable |-> hsCurrentEnable && protectEnable
         && spiAvailable)
      else $error("active permits incomplete");
   chk_low_power_perm:
      assert property (spiAvailable && !cellConvEnable |-> !hsCurrentEnable
         && protectEnable)
      else $error("low power permits wrong");
   chk_standby_no_link:
      assert property (inStandby |-> !spiDataOutEn && !cellConvEnable)
      else $error("link alive in standby");
   chk_standby_exit:
      assert property (longHold |-> ##[0:8] spiAvailable)
      else $error("long enable hold did not leave standby");
   chk_ls_needs_power:
      assert property (lsCurrentEnable |-> protectEnable)
      else $error("low speed current outside powered modes");
endmodule : omc_link_properties

//--- bench/omc_bench.sv
// Self-checking bench: APB drives the host, host drives the device.
// Assumes shortened watchdog and standby-exit counts.
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
   totalChecks++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
   end \
end
module omc_bench;
   localparam int STBY = 50;
   localparam int WDOG = 2000;
   localparam int LIMIT = 30000;
   logic coreClk = 1'b0;
   logic sysRst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic supplyPresent = 1'b0;
   logic cellConv, hsConv, lsConv, protect, spiAvail;
   logic [4:0] perm;
   logic [31:0] r;
   int failures = 0;
   int totalChecks = 0;
   int cycles = 0;
   // Rows: control word, mode status, permits {cell,hs,ls,prot,spi}
   logic [25:0] rows [4] = '{{16'h0009, 5'h02, 5'h03},
      {16'h0089, 5'h02, 5'h07}, {16'h0081, 5'h01, 5'h1F},
      {16'h0001, 5'h01, 5'h1B}};
   assign perm = {cellConv, hsConv, lsConv, protect, spiAvail};
   // Clock
   always #5 coreClk = ~coreClk;
   // ==========================================================
   // Ends of the link and the checker
   omc_link_if link ();
   omc_device #(.WDOG_CYCLES(WDOG), .STBY_CYCLES(STBY)) omc_device_inst (
      .core_clk(coreClk), .sys_rst(sysRst), .link(link),
      .supplyPresent(supplyPresent), .cellConvEnable(cellConv),
      .hsCurrentEnable(hsConv), .lsCurrentEnable(lsConv),
      .protectEnable(protect), .spiAvailable(spiAvail));
   omc_host omc_host_inst (.core_clk(coreClk), .sys_rst(sysRst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
      .link(link));
   omc_link_properties #(.STBY_CYCLES(STBY)) omc_link_properties_inst (
      .core_clk(coreClk), .sys_rst(sysRst), .spiEnable(link.spiEnable),
      .spiDataOutEn(link.spiDataOutEn),
      .powerResetOutEn(link.powerResetOutEn), .wakeInput(link.wakeInput),
      .shutdownControlIn(link.shutdownControlIn),
      .supplyPresent(supplyPresent), .cellConvEnable(cellConv),
      .hsCurrentEnable(hsConv), .lsCurrentEnable(lsConv),
      .protectEnable(protect), .spiAvailable(spiAvail));
   // ==========================================================
   // Tasks
   task automatic report_and_stop();
      $display("checks=%0d failures=%0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   // One APB transfer; read data kept in r
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge coreClk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge coreClk);
      penable <= 1'b1;
      do @(posedge coreClk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One device frame, waiting out busy and the device's update
   task automatic frame(input logic w, input logic [7:0] a,
         input logic [15:0] d);
      apb(1'b1, omc_pkg::APB_WDATA, {16'h0000, d});
      apb(1'b1, omc_pkg::APB_CMD, {15'h0000, w, 1'b0, a[6:0], 8'h00});
      r = 32'h1;
      while (r[0] !== 1'b0) apb(1'b0, omc_pkg::APB_STATUS, 32'h0);
      repeat (4) @(posedge coreClk);
      if (!w) apb(1'b0, omc_pkg::APB_RDATA, 32'h0);
   endtask : frame
   // Pin levels {enable hold, shutdown, wake}
   task automatic pins(input logic [2:0] p);
      apb(1'b1, omc_pkg::APB_PINS, {29'h0, p});
      repeat (10) @(posedge coreClk);
   endtask : pins
   // Hang guard
   always @(posedge coreClk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge coreClk);
      sysRst <= 1'b0;
      @(posedge coreClk);
      `CHECK(link.powerResetLine, 1'b0)
      `CHECK(perm, 5'h00)
      supplyPresent <= 1'b1;
      pins(3'b001);
      `CHECK(link.powerResetLine, 1'b1)
      `CHECK(perm, 5'h1B)
      pins(3'b000);
      frame(1'b0, omc_pkg::MODE_STATUS_ADDR, 16'h0000);
      `CHECK(r[15:0], 16'h0001)
      foreach (rows[i]) begin
         frame(1'b1, omc_pkg::MODE_CONTROL_ADDR, rows[i][25:10]);
         `CHECK(perm, rows[i][4:0])
         frame(1'b0, omc_pkg::MODE_STATUS_ADDR, 16'h0000);
         `CHECK(r[15:0], {11'h000, rows[i][9:5]})
      end
      // Soft reset with a stray low speed bit
      frame(1'b1, omc_pkg::MODE_CONTROL_ADDR, 16'h0080);
      apb(1'b0, omc_pkg::APB_STATUS, 32'h0);
      `CHECK(r[2], 1'b1)
      `CHECK(perm, 5'h1B)
      frame(1'b0, omc_pkg::MODE_CONTROL_ADDR, 16'h0000);
      `CHECK(r[15:0], omc_pkg::MODE_CONTROL_RESET)
      // Both selects, then enable hold short and long
      frame(1'b1, omc_pkg::MODE_CONTROL_ADDR, 16'h0019);
      `CHECK(perm, 5'h02)
      pins(3'b100);
      repeat (STBY / 4) @(posedge coreClk);
      `CHECK(perm, 5'h02)
      repeat (STBY) @(posedge coreClk);
      `CHECK(perm, 5'h1B)
      pins(3'b000);
      frame(1'b0, omc_pkg::MODE_STATUS_ADDR, 16'h0000);
      `CHECK(r[15:0], 16'h0001)
      // Watchdog kept alive by frames, then left to expire
      frame(1'b1, omc_pkg::MODE_CONTROL_ADDR, 16'h0101);
      repeat (2) begin
         repeat (WDOG * 3 / 4) @(posedge coreClk);
         frame(1'b0, omc_pkg::MODE_STATUS_ADDR, 16'h0000);
      end
      `CHECK(r[15:0], 16'h0001)
      repeat (WDOG + 100) @(posedge coreClk);
      `CHECK(link.powerResetLine, 1'b0)
      `CHECK(perm, 5'h00)
      // Shutdown input against wake
      pins(3'b001);
      `CHECK(perm, 5'h1B)
      pins(3'b010);
      `CHECK(link.powerResetLine, 1'b0)
      pins(3'b011);
      `CHECK(perm, 5'h00)
      report_and_stop();
   end
endmodule : omc_bench
